// >>> ialc_pkg.sv
// ialc_pkg: register map, field layout, timing constants, types and
// shared helper functions of the input level controller.
// assumes a 25 MHz core clock and signed 24-bit decimated samples.
package ialc_pkg;

	// ---------------------------------------------
	// register offsets
	// ---------------------------------------------
	localparam logic [6:0] ADDR_LIMITS = 7'h20;
	localparam logic [6:0] ADDR_TARGET = 7'h21;
	localparam logic [6:0] ADDR_MODE   = 7'h22;
	localparam logic [6:0] ADDR_NGATE  = 7'h23;
	localparam logic [6:0] ADDR_GAIN   = 7'h2D;

	// field positions
	localparam int EN_BIT    = 8;
	localparam int ZC_BIT    = 8;
	localparam int LIM_BIT   = 8;
	localparam int NG_EN_BIT = 3;
	localparam int MAX_LSB   = 3;
	localparam int HOLD_LSB  = 4;
	localparam int DCY_LSB   = 4;

	// values after reset
	localparam logic [8:0] RST_LIMITS = 9'h038;
	localparam logic [8:0] RST_TARGET = 9'h00B;
	localparam logic [8:0] RST_MODE   = 9'h032;
	localparam logic [8:0] RST_NGATE  = 9'h000;
	localparam logic [5:0] RST_GAIN   = 6'h10;

	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int CLK_HZ        = 25_000_000;
	localparam int US_PER_S      = 1_000_000;
	localparam int CYC_PER_US    = CLK_HZ / US_PER_S;
	localparam int US_PER_MS     = 1000;
	localparam int ATK_NORM_US   = 125;
	localparam int ATK_LIM_US    = 31;
	localparam int DCY_NORM_US   = 500;
	localparam int DCY_LIM_US    = 125;
	localparam int HOLD_UNIT_MS  = 1;
	localparam int HOLD_UNIT_US  = HOLD_UNIT_MS * US_PER_MS;
	localparam int ZC_TIMEOUT_MS = 250;
	localparam logic [3:0] MAX_RATE_CODE = 4'hA;

	// ---------------------------------------------
	// levels, in 0.75 dB units where signed
	// ---------------------------------------------
	localparam logic [22:0] CLIP_LEVEL       = 23'h700000;
	localparam int          PEAK_DECAY_SHIFT = 12;
	localparam logic signed [9:0] GAIN_ZERO_Q = 10'sh010;
	localparam logic signed [9:0] FS_Q        = 10'sh0B0;
	localparam logic signed [9:0] NG_BASE_Q   = -10'sh034;

	typedef struct packed {
		logic               vld;
		logic signed [23:0] data;
	} ialc_sample_t;

	typedef struct packed {
		logic       en;
		logic       lim;
		logic       zc;
		logic       ng_en;
		logic [2:0] ng_thr;
		logic [2:0] min;
		logic [2:0] max;
		logic [3:0] tgt;
		logic [3:0] hold;
		logic [3:0] atk;
		logic [3:0] dcy;
	} ialc_cfg_t;

	// peak level (top 12 bits) for target index; index 0 is lowest-1.5 dB
	function automatic logic [11:0] lvl_thr(input logic [4:0] idx);
		case (idx)
			5'h00: return 12'h082;
			5'h01: return 12'h09A;
			5'h02: return 12'h0B7;
			5'h03: return 12'h0D9;
			5'h04: return 12'h102;
			5'h05: return 12'h133;
			5'h06: return 12'h16D;
			5'h07: return 12'h1B2;
			5'h08: return 12'h204;
			5'h09: return 12'h265;
			5'h0A: return 12'h2D8;
			5'h0B: return 12'h362;
			5'h0C: return 12'h405;
			5'h0D: return 12'h4C7;
			5'h0E: return 12'h5AD;
			5'h0F: return 12'h6BF;
			default: return 12'h805;
		endcase
	endfunction

	// doubling interval in microseconds, code clamped to the last step
	function automatic logic [19:0] rate_us(input int base, input logic [3:0] code);
		logic [3:0] c;
		c = (code > MAX_RATE_CODE) ? MAX_RATE_CODE : code;
		return 20'(base) << c;
	endfunction

	// index of the highest set bit, zero for zero
	function automatic logic [4:0] msb_pos(input logic [22:0] v);
		logic [4:0] p;
		p = 5'h00;
		for (int i = 0; i < 23; i++)
			if (v[i])
				p = 5'(i);
		return p;
	endfunction

endpackage

// >>> ialc_src.sv
// ialc_src: decimator stand-in, one signed 1.23 sample per microsecond.
// assumes core_clk at 25 MHz; the bench sets the sample magnitude.
`timescale 1ns/1ps
module ialc_src #(
	parameter int GAP = 25
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	// wanted magnitude
	input  wire logic [22:0]       level,
	// sample stream
	output ialc_pkg::ialc_sample_t sample_out
);
	// ---------------------------------------------
	// sample pacing
	// ---------------------------------------------
	logic [7:0] cnt_ff;
	logic       sgn_ff;

	// sign alternates so zero crossings keep coming
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff     <= 8'h00;
			sgn_ff     <= 1'b0;
			sample_out <= '0;
		end else if (cnt_ff == 8'(GAP - 1)) begin
			cnt_ff          <= 8'h00;
			sgn_ff          <= ~sgn_ff;
			sample_out.vld  <= 1'b1;
			sample_out.data <= sgn_ff ? -$signed({1'b0, level}) : $signed({1'b0, level});
		end else begin
			cnt_ff          <= cnt_ff + 8'h01;
			sample_out.vld  <= 1'b0;
			// data is not held between strobes, so stale use shows up
			sample_out.data <= ~sample_out.data;
		end
	end
endmodule

// >>> ialc_tick_timer.sv
// ialc_tick_timer: interval timer paced by a microsecond enable,
// pulses fire for one cycle at the end of every period.
// assumes us_tick is a one-cycle enable from the same clock.
`timescale 1ns/1ps
module ialc_tick_timer (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// control
	input  wire logic        run,
	input  wire logic        us_tick,
	input  wire logic [19:0] period_us,
	// event
	output logic             fire
);
	logic [19:0] cnt_ff;
	logic        fire_ff;

	// a stopped timer restarts from zero so each period is whole
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff  <= 20'h00000;
			fire_ff <= 1'b0;
		end else if (!run) begin
			cnt_ff  <= 20'h00000;
			fire_ff <= 1'b0;
		end else if (us_tick) begin
			if (cnt_ff + 20'h00001 >= period_us) begin
				cnt_ff  <= 20'h00000;
				fire_ff <= 1'b1;
			end else begin
				cnt_ff  <= cnt_ff + 20'h00001;
				fire_ff <= 1'b0;
			end
		end else begin
			fire_ff <= 1'b0;
		end
	end

	assign fire = fire_ff;
endmodule

// >>> ialc_top.sv
// ialc_top: automatic level control for the input gain stage,
// driven by the decimated sample stream and a register port.
// assumes samples and register strobes are on core_clk.
// Operation
// - samples are signed 1.23 decimator output
// - peak loads larger magnitude, otherwise decays
// - control runs only while enable bit set
// - mode bit picks normal or limiter
// - disabled: gain held, changed by manual write
// - enabled: controller drives six-bit gain field
// - floor code maps -12 to 30 dB
// - ceiling code maps -6.75 to 35.25 dB
// - gain kept within limits, manual ignored
// - target field spans -28.5 to -6 dB
// - above target lowers, below target raises
// - hold time delays gain increase, normal mode
// - attack rate per mode, doubling per step
// - decay rate per mode, doubling per step
// - ticks skipped when peak disagrees with direction
// - limiter ceiling is gain at limiter start
// - near full scale, fastest attack always
// - noise gate holds gain instead of raising
// - noise gate only in enabled normal mode
// - gate flag when input-referred level below threshold
// - zero-cross gating of updates while enabled
// - zero-cross timeout applies gain after 0.25s
`timescale 1ns/1ps
module ialc_top #(
	parameter int ZC_TIMEOUT_US = ialc_pkg::ZC_TIMEOUT_MS * ialc_pkg::US_PER_MS
) (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   arst_n,
	// decimated sample stream
	input  wire ialc_pkg::ialc_sample_t sample_in,
	input  wire logic [5:0]             mic_boost_gain,
	// register port
	input  wire logic                   reg_wr_en,
	input  wire logic                   reg_rd_en,
	input  wire logic [6:0]             reg_addr,
	input  wire logic [8:0]             reg_wr_data,
	output logic [8:0]                  reg_rd_data,
	// gain stage
	output logic [5:0]                  amp_gain_value,
	output logic                        noise_gate_flag
);
	// ---------------------------------------------
	// register file
	// ---------------------------------------------
	logic [8:0] limits_ff;
	logic [8:0] target_ff;
	logic [8:0] mode_ff;
	logic [8:0] ngate_ff;
	logic [8:0] rd_ff;
	logic       wr_limits;
	logic       wr_target;
	logic       wr_mode;
	logic       wr_ngate;
	logic       man_wr;
	ialc_pkg::ialc_cfg_t cfg;

	// write decode
	always_comb begin
		wr_limits = 1'b0;
		wr_target = 1'b0;
		wr_mode   = 1'b0;
		wr_ngate  = 1'b0;
		man_wr    = 1'b0;
		if (reg_wr_en && reg_addr == ialc_pkg::ADDR_LIMITS)
			wr_limits = 1'b1;
		else if (reg_wr_en && reg_addr == ialc_pkg::ADDR_TARGET)
			wr_target = 1'b1;
		else if (reg_wr_en && reg_addr == ialc_pkg::ADDR_MODE)
			wr_mode = 1'b1;
		else if (reg_wr_en && reg_addr == ialc_pkg::ADDR_NGATE)
			wr_ngate = 1'b1;
		else if (reg_wr_en && reg_addr == ialc_pkg::ADDR_GAIN)
			man_wr = 1'b1;
	end

	// configuration storage
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			limits_ff <= ialc_pkg::RST_LIMITS;
			target_ff <= ialc_pkg::RST_TARGET;
			mode_ff   <= ialc_pkg::RST_MODE;
			ngate_ff  <= ialc_pkg::RST_NGATE;
		end else begin
			if (wr_limits)
				limits_ff <= reg_wr_data;
			if (wr_target)
				target_ff <= reg_wr_data;
			if (wr_mode)
				mode_ff <= reg_wr_data;
			if (wr_ngate)
				ngate_ff <= {5'h00, reg_wr_data[3:0]};
		end
	end

	// field split
	always_comb begin
		cfg.en     = limits_ff[ialc_pkg::EN_BIT];
		cfg.lim    = mode_ff[ialc_pkg::LIM_BIT];
		cfg.zc     = target_ff[ialc_pkg::ZC_BIT];
		cfg.ng_en  = ngate_ff[ialc_pkg::NG_EN_BIT];
		cfg.ng_thr = ngate_ff[2:0];
		cfg.min    = limits_ff[2:0];
		cfg.max    = limits_ff[ialc_pkg::MAX_LSB +: 3];
		cfg.tgt    = target_ff[3:0];
		cfg.hold   = target_ff[ialc_pkg::HOLD_LSB +: 4];
		cfg.atk    = mode_ff[3:0];
		cfg.dcy    = mode_ff[ialc_pkg::DCY_LSB +: 4];
	end

	// read port; the gain address shows the applied gain
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			rd_ff <= 9'h000;
		else if (!reg_rd_en)
			rd_ff <= rd_ff;
		else if (reg_addr == ialc_pkg::ADDR_LIMITS)
			rd_ff <= limits_ff;
		else if (reg_addr == ialc_pkg::ADDR_TARGET)
			rd_ff <= target_ff;
		else if (reg_addr == ialc_pkg::ADDR_MODE)
			rd_ff <= mode_ff;
		else if (reg_addr == ialc_pkg::ADDR_NGATE)
			rd_ff <= ngate_ff;
		else if (reg_addr == ialc_pkg::ADDR_GAIN)
			rd_ff <= {3'h0, amp_gain_value};
		else
			rd_ff <= 9'h000;
	end
	assign reg_rd_data = rd_ff;

	// ---------------------------------------------
	// microsecond enable
	// ---------------------------------------------
	logic [4:0] us_cnt_ff;
	logic       us_tick_ff;

	// all rate timers share this enable instead of a second clock
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			us_cnt_ff  <= 5'h00;
			us_tick_ff <= 1'b0;
		end else if (us_cnt_ff == 5'(ialc_pkg::CYC_PER_US - 1)) begin
			us_cnt_ff  <= 5'h00;
			us_tick_ff <= 1'b1;
		end else begin
			us_cnt_ff  <= us_cnt_ff + 5'h01;
			us_tick_ff <= 1'b0;
		end
	end

	// ---------------------------------------------
	// peak detector and comparisons
	// ---------------------------------------------
	logic [22:0] mag;
	logic [22:0] peak_ff;
	logic        sign_ff;
	logic        zc_evt;
	logic        above_tgt;
	logic        above_lo;
	logic        clip_ff;

	// magnitude of a 1.23 sample; the most negative code saturates
	always_comb begin
		if (!sample_in.data[23])
			mag = sample_in.data[22:0];
		else if (sample_in.data[22:0] == 23'h000000)
			mag = 23'h7FFFFF;
		else
			mag = 23'(-sample_in.data[22:0]);
	end

	// load on a larger sample, otherwise decay once per sample
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			peak_ff <= 23'h000000;
		else if (sample_in.vld && mag > peak_ff)
			peak_ff <= mag;
		else if (sample_in.vld)
			peak_ff <= peak_ff - (peak_ff >> ialc_pkg::PEAK_DECAY_SHIFT);
	end

	// sign history for zero-crossing detection
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			sign_ff <= 1'b0;
		else if (sample_in.vld)
			sign_ff <= sample_in.data[23];
	end
	assign zc_evt = sample_in.vld && (sample_in.data[23] != sign_ff);

	// target window on the top 12 bits of the peak
	assign above_tgt = peak_ff[22:11] > ialc_pkg::lvl_thr({1'b0, cfg.tgt} + 5'h01);
	assign above_lo  = peak_ff[22:11] > ialc_pkg::lvl_thr({1'b0, cfg.tgt});

	// emergency flag, released once a sample falls back under the level
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			clip_ff <= 1'b0;
		else if (sample_in.vld)
			clip_ff <= mag > ialc_pkg::CLIP_LEVEL;
	end

	// ---------------------------------------------
	// noise gate
	// ---------------------------------------------
	logic signed [9:0] sig_q;
	logic signed [9:0] thr_q;
	logic              gate_ff;
	logic              gate_act;

	// input-referred level in 0.75 dB units, 6 dB per peak bit
	always_comb begin
		sig_q = $signed({2'b00, ialc_pkg::msb_pos(peak_ff), 3'b000}) - ialc_pkg::FS_Q;
		sig_q = sig_q - ($signed({4'h0, amp_gain_value}) - ialc_pkg::GAIN_ZERO_Q);
		sig_q = sig_q - $signed({4'h0, mic_boost_gain});
		thr_q = ialc_pkg::NG_BASE_Q - $signed({4'h0, cfg.ng_thr, 3'b000});
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			gate_ff <= 1'b0;
		else if (sample_in.vld)
			gate_ff <= sig_q < thr_q;
	end
	assign noise_gate_flag = gate_ff;
	assign gate_act = cfg.en && !cfg.lim && cfg.ng_en && gate_ff;

	// ---------------------------------------------
	// rate timers
	// ---------------------------------------------
	logic [19:0] atk_per;
	logic [19:0] dcy_per;
	logic [19:0] hold_per;
	logic        atk_fire;
	logic        dcy_fire;
	logic        hold_fire;
	logic        hold_ok_ff;
	logic        hold_ok;
	logic        zc_fire;
	logic [5:0]  ctrl_ff;

	// limiter runs faster tables; clipping forces the first attack step
	always_comb begin
		atk_per  = ialc_pkg::rate_us(cfg.lim ? ialc_pkg::ATK_LIM_US : ialc_pkg::ATK_NORM_US,
			clip_ff ? 4'h0 : cfg.atk);
		dcy_per  = ialc_pkg::rate_us(cfg.lim ? ialc_pkg::DCY_LIM_US : ialc_pkg::DCY_NORM_US,
			cfg.dcy);
		hold_per = ialc_pkg::rate_us(ialc_pkg::HOLD_UNIT_US, cfg.hold - 4'h1);
	end

	ialc_tick_timer u_atk (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.run       (cfg.en),
		.us_tick   (us_tick_ff),
		.period_us (atk_per),
		.fire      (atk_fire)
	);

	ialc_tick_timer u_dcy (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.run       (cfg.en),
		.us_tick   (us_tick_ff),
		.period_us (dcy_per),
		.fire      (dcy_fire)
	);

	ialc_tick_timer u_hold (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.run       (cfg.en && !cfg.lim && !above_lo && !hold_ok_ff),
		.us_tick   (us_tick_ff),
		.period_us (hold_per),
		.fire      (hold_fire)
	);

	ialc_tick_timer u_zc (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.run       (cfg.en && cfg.zc && ctrl_ff != amp_gain_value),
		.us_tick   (us_tick_ff),
		.period_us (20'(ZC_TIMEOUT_US)),
		.fire      (zc_fire)
	);

	// hold window restarts whenever the envelope returns to range
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			hold_ok_ff <= 1'b0;
		else if (!cfg.en || above_lo)
			hold_ok_ff <= 1'b0;
		else if (hold_fire)
			hold_ok_ff <= 1'b1;
	end
	assign hold_ok = cfg.lim || cfg.hold == 4'h0 || hold_ok_ff;

	// ---------------------------------------------
	// gain control
	// ---------------------------------------------
	logic [5:0] floor_gain;
	logic [5:0] ceiling_gain;
	logic [5:0] ceil_eff;
	logic [5:0] lim_ceil_ff;
	logic       lim_prev_ff;
	logic       lim_act;

	assign lim_act      = cfg.en && cfg.lim;
	assign floor_gain   = {cfg.min, 3'b000};
	// on the entry cycle the captured ceiling is not loaded yet, so use the live gain
	assign ceiling_gain = !lim_act ? {cfg.max, 3'b111} : (lim_prev_ff ? lim_ceil_ff : ctrl_ff);
	// a floor above the ceiling wins, so the gain never oscillates
	assign ceil_eff     = (ceiling_gain < floor_gain) ? floor_gain : ceiling_gain;

	// capture the limiter ceiling on entry to limiter operation
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			lim_prev_ff <= 1'b0;
			lim_ceil_ff <= ialc_pkg::RST_GAIN;
		end else begin
			lim_prev_ff <= lim_act;
			if (lim_act && !lim_prev_ff)
				lim_ceil_ff <= ctrl_ff;
		end
	end

	// one code step per tick; clamps first, then attack before decay
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			ctrl_ff <= ialc_pkg::RST_GAIN;
		else if (!cfg.en) begin
			if (man_wr)
				ctrl_ff <= reg_wr_data[5:0];
		end else if (ctrl_ff < floor_gain)
			ctrl_ff <= floor_gain;
		else if (ctrl_ff > ceil_eff)
			ctrl_ff <= ceil_eff;
		else if (atk_fire && (clip_ff || above_tgt) && ctrl_ff > floor_gain)
			ctrl_ff <= ctrl_ff - 6'h01;
		else if (dcy_fire && !clip_ff && !above_lo && hold_ok && !gate_act && ctrl_ff < ceil_eff)
			ctrl_ff <= ctrl_ff + 6'h01;
	end

	// applied gain waits for a zero crossing or the timeout when gated
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			amp_gain_value <= ialc_pkg::RST_GAIN;
		else if (!cfg.en || !cfg.zc)
			amp_gain_value <= ctrl_ff;
		else if (zc_evt || zc_fire)
			amp_gain_value <= ctrl_ff;
	end

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	property p_peak_load;
		sample_in.vld && mag > peak_ff |=> peak_ff == $past(mag);
	endproperty
	a_peak_load: assert property (p_peak_load) else $error("peak not loaded");

	property p_off_hold;
		!cfg.en && !man_wr ##1 !cfg.en |-> $stable(ctrl_ff);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("gain moved while off");

	property p_manual;
		!cfg.en && man_wr |=> ##1 amp_gain_value == $past(reg_wr_data[5:0], 2);
	endproperty
	a_manual: assert property (p_manual) else $error("manual gain lost");

	property p_manual_ignored;
		cfg.en && man_wr && !atk_fire && !dcy_fire && ctrl_ff >= floor_gain && ctrl_ff <= ceil_eff
			|=> $stable(ctrl_ff);
	endproperty
	a_manual_ignored: assert property (p_manual_ignored) else $error("manual write acted");

	property p_clip_attack;
		cfg.en && atk_fire && clip_ff && ctrl_ff > floor_gain && ctrl_ff <= ceil_eff
			|=> ctrl_ff == $past(ctrl_ff) - 6'h01;
	endproperty
	a_clip_attack: assert property (p_clip_attack) else $error("clip step missed");

	property p_no_decrease;
		cfg.en && atk_fire && !clip_ff && !above_tgt && ctrl_ff >= floor_gain && ctrl_ff <= ceil_eff
			|=> ctrl_ff >= $past(ctrl_ff);
	endproperty
	a_no_decrease: assert property (p_no_decrease) else $error("gain fell below target");

	property p_gate_holds;
		gate_act && ctrl_ff >= floor_gain && ctrl_ff <= ceil_eff |=> ctrl_ff <= $past(ctrl_ff);
	endproperty
	a_gate_holds: assert property (p_gate_holds) else $error("gated gain rose");

	property p_lim_ceiling;
		lim_act && lim_prev_ff && ctrl_ff <= ceil_eff ##1 lim_act |-> ctrl_ff <= ceil_eff;
	endproperty
	a_lim_ceiling: assert property (p_lim_ceiling) else $error("limiter ceiling passed");

	property p_zc_wait;
		cfg.en && cfg.zc && !zc_evt && !zc_fire |=> $stable(amp_gain_value);
	endproperty
	a_zc_wait: assert property (p_zc_wait) else $error("gain applied off crossing");

	property p_step_one;
		cfg.en && $past(cfg.en) && $past(ctrl_ff) >= $past(floor_gain)
			&& $past(ctrl_ff) <= $past(ceil_eff) && ctrl_ff != $past(ctrl_ff)
			|-> (ctrl_ff == $past(ctrl_ff) + 6'h01) || (ctrl_ff == $past(ctrl_ff) - 6'h01);
	endproperty
	a_step_one: assert property (p_step_one) else $error("gain jumped");

endmodule

// >>> ialc_top_tb.sv
// ialc_top_tb: register-driven sequences against the level controller.
// assumes a 25 MHz clock; rate codes kept short so the run stays brief.
`timescale 1ns/1ps
module ialc_top_tb;
	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic                   core_clk;
	logic                   arst_n;
	ialc_pkg::ialc_sample_t sample_in;
	logic [22:0]            level;
	logic [5:0]             mic_boost;
	logic                   reg_wr_en;
	logic                   reg_rd_en;
	logic [6:0]             reg_addr;
	logic [8:0]             reg_wr_data;
	logic [8:0]             reg_rd_data;
	logic [5:0]             amp_gain_value;
	logic                   noise_gate_flag;
	int                     n_errors;
	int                     samples_checked;

	ialc_top #(.ZC_TIMEOUT_US(50)) uut (
		.core_clk       (core_clk),
		.arst_n         (arst_n),
		.sample_in      (sample_in),
		.mic_boost_gain (mic_boost),
		.reg_wr_en      (reg_wr_en),
		.reg_rd_en      (reg_rd_en),
		.reg_addr       (reg_addr),
		.reg_wr_data    (reg_wr_data),
		.reg_rd_data    (reg_rd_data),
		.amp_gain_value (amp_gain_value),
		.noise_gate_flag(noise_gate_flag)
	);

	ialc_src src (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.level     (level),
		.sample_out(sample_in)
	);

	// 25 MHz
	initial core_clk = 1'b0;
	always #20 core_clk = ~core_clk;

	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		@(posedge core_clk);
		reg_wr_en   <= 1'b1;
		reg_addr    <= a;
		reg_wr_data <= d;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
	endtask

	// read data lands one edge after the strobe
	task automatic rd(input logic [6:0] a, input logic [8:0] exp, input string what);
		@(posedge core_clk);
		reg_rd_en <= 1'b1;
		reg_addr  <= a;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		#1;
		check(reg_rd_data, exp, what);
	endtask

	// fixed waits only: rate timers have no completion signal
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic gain(input logic [5:0] exp, input string what);
		check({3'h0, amp_gain_value}, {3'h0, exp}, what);
	endtask

	// tick phase is free, so timed steps land in a window
	task automatic gain_in(input logic [5:0] lo, input logic [5:0] hi, input string what);
		check(9'(amp_gain_value >= lo && amp_gain_value <= hi), 9'h001, what);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ---------------------------------------------
	// sequence
	// ---------------------------------------------
	initial begin
		arst_n          = 1'b0;
		level           = 23'h000000;
		mic_boost       = 6'h00;
		reg_wr_en       = 1'b0;
		reg_rd_en       = 1'b0;
		reg_addr        = 7'h00;
		reg_wr_data     = 9'h000;
		n_errors        = 0;
		samples_checked = 0;
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		// register map, masking, unmapped space
		rd(ialc_pkg::ADDR_LIMITS, ialc_pkg::RST_LIMITS, "limits");
		rd(ialc_pkg::ADDR_TARGET, ialc_pkg::RST_TARGET, "target");
		rd(ialc_pkg::ADDR_MODE, ialc_pkg::RST_MODE, "mode");
		rd(ialc_pkg::ADDR_NGATE, ialc_pkg::RST_NGATE, "gate");
		rd(ialc_pkg::ADDR_GAIN, 9'h010, "gain");
		wr(ialc_pkg::ADDR_NGATE, 9'h1FF);
		rd(ialc_pkg::ADDR_NGATE, 9'h00F, "gate mask");
		wr(7'h24, 9'h1FF);
		rd(7'h24, 9'h000, "unmapped");
		$display("test registers done");
		// manual gain, then floor and override once enabled
		wr(ialc_pkg::ADDR_NGATE, 9'h000);
		wr(ialc_pkg::ADDR_GAIN, 9'h000);
		wait_cyc(3);
		gain(6'h00, "manual");
		wr(ialc_pkg::ADDR_LIMITS, 9'h13A);
		wait_cyc(4);
		gain(6'h10, "floor");
		wr(ialc_pkg::ADDR_GAIN, 9'h005);
		wait_cyc(3);
		gain(6'h10, "override");
		wr(ialc_pkg::ADDR_LIMITS, 9'h03A);
		wr(ialc_pkg::ADDR_GAIN, 9'h03F);
		wr(ialc_pkg::ADDR_LIMITS, 9'h108);
		wait_cyc(4);
		gain(6'h0F, "ceiling");
		$display("test limits done");
		// quiet input: decay raises one code per 500 us
		wr(ialc_pkg::ADDR_LIMITS, 9'h038);
		wr(ialc_pkg::ADDR_GAIN, 9'h010);
		wr(ialc_pkg::ADDR_MODE, 9'h000);
		wr(ialc_pkg::ADDR_LIMITS, 9'h138);
		wait_cyc(600 * 25);
		gain_in(6'h11, 6'h12, "decay");
		// limiter never climbs past its entry gain
		wr(ialc_pkg::ADDR_LIMITS, 9'h038);
		wr(ialc_pkg::ADDR_GAIN, 9'h014);
		wr(ialc_pkg::ADDR_MODE, 9'h100);
		wr(ialc_pkg::ADDR_LIMITS, 9'h138);
		wait_cyc(300 * 25);
		gain(6'h14, "limiter");
		$display("test decay done");
		// silence with the gate on holds the gain
		wr(ialc_pkg::ADDR_LIMITS, 9'h038);
		wr(ialc_pkg::ADDR_GAIN, 9'h010);
		wr(ialc_pkg::ADDR_MODE, 9'h000);
		wr(ialc_pkg::ADDR_NGATE, 9'h008);
		wr(ialc_pkg::ADDR_LIMITS, 9'h138);
		wait_cyc(600 * 25);
		gain(6'h10, "gated");
		check({8'h00, noise_gate_flag}, 9'h001, "gate flag");
		$display("test gate done");
		// loud input under the slowest attack code: no step yet
		level <= 23'h400000;
		wr(ialc_pkg::ADDR_MODE, 9'h00A);
		wait_cyc(300 * 25);
		gain(6'h10, "slow attack");
		check({8'h00, noise_gate_flag}, 9'h000, "gate open");
		// a large boost pushes the input-referred level under the threshold
		@(posedge core_clk);
		mic_boost <= 6'h3F;
		wait_cyc(3 * 25);
		check({8'h00, noise_gate_flag}, 9'h001, "boost gates");
		@(posedge core_clk);
		mic_boost <= 6'h00;
		wait_cyc(3 * 25);
		check({8'h00, noise_gate_flag}, 9'h000, "boost off");
		// fastest code: a step per 125 us
		wr(ialc_pkg::ADDR_MODE, 9'h000);
		wait_cyc(300 * 25);
		gain_in(6'h0D, 6'h0E, "attack");
		// near full scale the code is overruled
		wr(ialc_pkg::ADDR_MODE, 9'h00A);
		level <= 23'h7F0000;
		wait_cyc(300 * 25);
		gain_in(6'h0A, 6'h0C, "clip");
		$display("test attack done");
		// disabled: gain frozen until a manual write
		wr(ialc_pkg::ADDR_LIMITS, 9'h038);
		wait_cyc(300 * 25);
		gain_in(6'h0A, 6'h0C, "frozen");
		wr(ialc_pkg::ADDR_GAIN, 9'h022);
		wait_cyc(3);
		gain(6'h22, "manual again");
		$display("test disable done");
		tally_and_finish();
	end
endmodule
